/* common/thresh_pkg.sv */
package thresh_pkg;
   // ==========================================================
   // Channel and data widths
   localparam int NUM_CH = 8;
   localparam int VAL_W = 16;

   // ==========================================================
   // Register map (byte addresses, one page of 0x20 per channel)
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h004;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
   localparam logic [11:0] OFS_OUT_STATE = 12'h00C;
   localparam logic [11:0] OFS_CH_BASE = 12'h100;
   localparam int CH_SHIFT = 5;
   localparam logic [4:0] OFS_CH_CTRL = 5'h00;
   localparam logic [4:0] OFS_CH_LIMITS = 5'h04;
   localparam logic [4:0] OFS_CH_DELAY = 5'h08;
   localparam logic [4:0] OFS_CH_HOLD = 5'h0C;
   localparam logic [4:0] OFS_CH_DUTY = 5'h10;
   localparam logic [4:0] OFS_CH_INPUT = 5'h14;

   // ==========================================================
   // Control register fields
   localparam int CTRL_WINDOW = 0;
   localparam int CTRL_FAULT_LO = 1;
   localparam int CTRL_INVERT = 3;
   localparam int CTRL_SC_EN = 4;
   localparam int CTRL_PR_EN = 5;
   localparam int CTRL_ERROR = 6;
   localparam int CTRL_ENABLE = 7;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_LOWER = 16'h0000;
   localparam logic [15:0] RST_UPPER = 16'h0064;
   localparam logic [31:0] RST_DELAY = 32'h0000_0000;
   localparam logic [31:0] RST_HOLD = 32'h0000_0000;
   localparam logic [6:0] RST_DUTY = 7'h32;
   localparam logic [7:0] RST_CTRL = 8'h12; // Short detect on, fault turns off

   // ==========================================================
   // Timing: delays and hold times count in 1 ms ticks
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   // Reduced PWM period of one tick, duty steps in percent
   localparam int PWM_STEPS = 100;
   localparam int PWM_STEP_CYCLES = 1000;

   typedef enum logic [1:0] {FAULT_LAST, FAULT_OFF, FAULT_ON, FAULT_RSV} fault_mode_t;

   typedef struct packed {
      logic enable;
      logic error;
      logic pr_en;
      logic sc_en;
      logic invert;
      fault_mode_t fault;
      logic window;
   } ch_ctrl_t;

   typedef struct packed {
      ch_ctrl_t ctrl;
      logic [VAL_W-1:0] lower;
      logic [VAL_W-1:0] upper;
      logic [31:0] delay;
      logic [31:0] hold;
      logic [6:0] duty;
      logic [VAL_W-1:0] value;
   } ch_cfg_t;
endpackage

/* hdl/tick_divider.sv */
`timescale 1ns/10ps
module tick_divider #(
   parameter int DIV = 100000
)(
   input wire logic mclk_i,
   input wire logic resetn_i,
   output logic tick_o
);
   localparam int CW = $clog2(DIV + 1);
   logic [CW-1:0] count;

   initial
   begin
      if (DIV < 1)
         $error("tick_divider: DIV must be at least 1");
   end

   // ==========================================================
   // Divider producing a one-cycle enable
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         count <= '0;
         tick_o <= 1'b0;
      end
      else if (count == CW'(DIV - 1))
      begin
         count <= '0;
         tick_o <= 1'b1;
      end
      else
      begin
         count <= count + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule // tick_divider

/* hdl/threshold_channel.sv */
`timescale 1ns/10ps
module threshold_channel (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic tick_i,
   input wire logic pwm_tick_i,
   input wire logic [6:0] pwm_phase_i,
   input wire thresh_pkg::ch_cfg_t cfg_i,
   input wire logic short_i,
   output logic out_o,
   output logic cond_o,
   output logic short_evt_o
);
   logic cond;
   logic next_cond;
   logic state;
   logic [31:0] delay_cnt;
   logic [31:0] hold_cnt;
   logic reduced;
   logic logical_out;
   logic last_valid;
   logic driven;

   // ==========================================================
   // Comparator: window or hysteresis
   always_comb
   begin
      if (cfg_i.ctrl.window)
         next_cond = (cfg_i.value >= cfg_i.lower) && (cfg_i.value <= cfg_i.upper);
      else if (cfg_i.value > cfg_i.upper)
         next_cond = 1'b1;
      else if (cfg_i.value < cfg_i.lower)
         next_cond = 1'b0;
      else
         next_cond = cond;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         cond <= 1'b0;
      else
         cond <= next_cond;
   end

   // ==========================================================
   // Switching delay: the condition must hold for the whole delay
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         state <= 1'b0;
         delay_cnt <= '0;
      end
      else if (cond == state)
         delay_cnt <= '0;
      else if (delay_cnt >= cfg_i.delay)
      begin
         state <= cond;
         delay_cnt <= '0;
      end
      else if (tick_i)
         delay_cnt <= delay_cnt + 1'b1;
   end

   // ==========================================================
   // Power reduction hold timer, restarted at every off period
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         hold_cnt <= '0;
         reduced <= 1'b0;
      end
      else if (!state || !cfg_i.ctrl.pr_en)
      begin
         hold_cnt <= '0;
         reduced <= 1'b0;
      end
      else if (hold_cnt >= cfg_i.hold)
         reduced <= 1'b1;
      else if (tick_i)
         hold_cnt <= hold_cnt + 1'b1;
   end

   // duty percent gates the reduced output
   assign logical_out = state && (!reduced || (pwm_phase_i < cfg_i.duty));

   // ==========================================================
   // Fault substitution and inversion
   always_comb
   begin
      if (cfg_i.ctrl.error)
      begin
         case (cfg_i.ctrl.fault)
            thresh_pkg::FAULT_LAST: driven = last_valid;
            thresh_pkg::FAULT_ON: driven = 1'b1;
            default: driven = 1'b0;
         endcase
      end
      else
         driven = logical_out;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         last_valid <= 1'b0;
         out_o <= 1'b0;
         short_evt_o <= 1'b0;
      end
      else
      begin
         if (!cfg_i.ctrl.error)
            last_valid <= logical_out;
         out_o <= cfg_i.ctrl.enable & (driven ^ cfg_i.ctrl.invert);
         short_evt_o <= cfg_i.ctrl.sc_en & short_i & out_o;
      end
   end

   assign cond_o = state;

   // ==========================================================
   // Checks
   // zero delay follows next cycle
   zero_delay_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (cfg_i.delay == 0 && cond != state) |=> (state == $past(cond)))
      else $error("zero delay did not switch");
   invert_out_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (cfg_i.ctrl.enable && !cfg_i.ctrl.error && $stable(cfg_i)) ##1 $stable(cfg_i)
      |-> out_o == ($past(logical_out) ^ cfg_i.ctrl.invert))
      else $error("inversion wrong");
   fault_on_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (cfg_i.ctrl.enable && cfg_i.ctrl.error && cfg_i.ctrl.fault == thresh_pkg::FAULT_ON
       && !cfg_i.ctrl.invert) |=> out_o)
      else $error("fault on not applied");
   hyst_on_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!cfg_i.ctrl.window && cfg_i.value > cfg_i.upper) |=> cond)
      else $error("hysteresis did not turn on");
   window_in_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (cfg_i.ctrl.window && cfg_i.value >= cfg_i.lower && cfg_i.value <= cfg_i.upper) |=> cond)
      else $error("window inside not seen");
   no_reduce_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !state |=> !reduced)
      else $error("reduced while off");
   // no switch while condition equals state
   hold_state_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (cond == state) |=> $stable(state))
      else $error("state switched without cause");
   short_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !cfg_i.ctrl.sc_en |=> !short_evt_o)
      else $error("short event while disabled");
endmodule // threshold_channel

/* hdl/threshold_switch_output.sv */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module threshold_switch_output #(
   parameter int NUM_CH = thresh_pkg::NUM_CH,
   parameter int TICK_CYCLES = thresh_pkg::TICK_CYCLES,
   parameter int PWM_STEP_CYCLES = thresh_pkg::PWM_STEP_CYCLES
)(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [7:0] short_i,
   output logic [7:0] out_o,
   output logic irq_o
);
   thresh_pkg::ch_cfg_t cfg [NUM_CH];
   logic [NUM_CH-1:0] ch_out;
   logic [NUM_CH-1:0] ch_cond;
   logic [NUM_CH-1:0] ch_short;
   logic [NUM_CH-1:0] cond_d;
   logic [2*NUM_CH-1:0] irq_status;
   logic [2*NUM_CH-1:0] irq_enable;
   logic [2*NUM_CH-1:0] irq_event;
   logic [2*NUM_CH-1:0] irq_clear;
   logic tick;
   logic pwm_tick;
   logic [6:0] pwm_phase;
   logic wr_pend;
   logic [11:0] wr_addr;
   logic [11:0] rd_addr;
   logic [31:0] next_rdata;

   initial
   begin
      if (NUM_CH < 1 || NUM_CH > 8)
         $error("threshold_switch_output: NUM_CH must be 1 to 8");
   end

   // ==========================================================
   // Address decode helpers
   function automatic logic is_ch(input logic [11:0] a);
      return a >= thresh_pkg::OFS_CH_BASE && a < 12'(thresh_pkg::OFS_CH_BASE + (NUM_CH << thresh_pkg::CH_SHIFT));
   endfunction

   function automatic logic [2:0] ch_idx(input logic [11:0] a);
      return 3'((a - thresh_pkg::OFS_CH_BASE) >> thresh_pkg::CH_SHIFT);
   endfunction

   function automatic logic wr_hit(input logic [11:0] ofs);
      return wr_pend && wr_addr == ofs;
   endfunction

   // ==========================================================
   // Timebase: millisecond tick and reduced PWM phase
   tick_divider #(.DIV(TICK_CYCLES)) ms_div (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .tick_o(tick)
   );

   tick_divider #(.DIV(PWM_STEP_CYCLES)) pwm_div (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .tick_o(pwm_tick)
   );

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         pwm_phase <= '0;
      else if (pwm_tick)
         pwm_phase <= (pwm_phase == 7'(thresh_pkg::PWM_STEPS - 1)) ? 7'h00 : pwm_phase + 7'h01;
   end

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // Capture address phase
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end
      else if (hready_i)
      begin
         wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
         wr_addr <= {haddr_i[11:2], 2'b00};
      end
   end

   assign rd_addr = {haddr_i[11:2], 2'b00};

   // Read mux, unmapped reads as zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (is_ch(rd_addr))
      begin
         case (rd_addr[4:0])
            thresh_pkg::OFS_CH_CTRL: next_rdata = {23'h0, ch_cond[ch_idx(rd_addr)], cfg[ch_idx(rd_addr)].ctrl};
            thresh_pkg::OFS_CH_LIMITS: next_rdata = {cfg[ch_idx(rd_addr)].upper, cfg[ch_idx(rd_addr)].lower};
            thresh_pkg::OFS_CH_DELAY: next_rdata = cfg[ch_idx(rd_addr)].delay;
            thresh_pkg::OFS_CH_HOLD: next_rdata = cfg[ch_idx(rd_addr)].hold;
            thresh_pkg::OFS_CH_DUTY: next_rdata = {25'h0, cfg[ch_idx(rd_addr)].duty};
            thresh_pkg::OFS_CH_INPUT: next_rdata = {16'h0, cfg[ch_idx(rd_addr)].value};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      else
      begin
         case (rd_addr)
            thresh_pkg::OFS_IRQ_STATUS: next_rdata = 32'(irq_status);
            thresh_pkg::OFS_IRQ_ENABLE: next_rdata = 32'(irq_enable);
            thresh_pkg::OFS_OUT_STATE: next_rdata = {16'h0, 8'(ch_cond), out_o};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         hrdata_o <= 32'h0000_0000;
      else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
         hrdata_o <= next_rdata;
   end

   // ==========================================================
   // Per-channel configuration registers and channel logic
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : ch
         always_ff @(posedge mclk_i)
         begin
            if (!resetn_i)
            begin
               cfg[g].ctrl <= thresh_pkg::RST_CTRL;
               // limits reset to 0 and 100
               cfg[g].lower <= thresh_pkg::RST_LOWER;
               cfg[g].upper <= thresh_pkg::RST_UPPER;
               cfg[g].delay <= thresh_pkg::RST_DELAY;
               cfg[g].hold <= thresh_pkg::RST_HOLD;
               cfg[g].duty <= thresh_pkg::RST_DUTY;
               cfg[g].value <= '0;
            end
            else if (wr_pend && is_ch(wr_addr) && ch_idx(wr_addr) == 3'(g))
            begin
               case (wr_addr[4:0])
                  thresh_pkg::OFS_CH_CTRL: cfg[g].ctrl <= hwdata_i[7:0];
                  thresh_pkg::OFS_CH_LIMITS:
                  begin
                     cfg[g].lower <= hwdata_i[15:0];
                     cfg[g].upper <= hwdata_i[31:16];
                  end
                  thresh_pkg::OFS_CH_DELAY: cfg[g].delay <= hwdata_i;
                  thresh_pkg::OFS_CH_HOLD: cfg[g].hold <= hwdata_i;
                  thresh_pkg::OFS_CH_DUTY: cfg[g].duty <= (hwdata_i[6:0] > 7'h64) ? 7'h64 : hwdata_i[6:0];
                  thresh_pkg::OFS_CH_INPUT: cfg[g].value <= hwdata_i[15:0];
                  default: ;
               endcase
            end
         end

         threshold_channel chan (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .tick_i(tick),
            .pwm_tick_i(pwm_tick),
            .pwm_phase_i(pwm_phase),
            .cfg_i(cfg[g]),
            .short_i(short_i[g]),
            .out_o(ch_out[g]),
            .cond_o(ch_cond[g]),
            .short_evt_o(ch_short[g])
         );

         assign out_o[g] = ch_out[g];
         assign irq_event[g] = ch_cond[g] ^ cond_d[g];
         assign irq_event[NUM_CH + g] = ch_short[g];
      end
      for (g = NUM_CH; g < 8; g++)
      begin : unused
         assign out_o[g] = 1'b0;
      end
   endgenerate

   // ==========================================================
   // Interrupts: switch events and short events, set wins over clear
   assign irq_clear = wr_hit(thresh_pkg::OFS_IRQ_CLEAR) ? hwdata_i[2*NUM_CH-1:0] : '0;

   // Previous switched state for change events
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         cond_d <= '0;
      else
         cond_d <= ch_cond;
   end

   // Sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~irq_clear) | irq_event;
   end

   // Interrupt enable mask
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         irq_enable <= '0;
      else if (wr_hit(thresh_pkg::OFS_IRQ_ENABLE))
         irq_enable <= hwdata_i[2*NUM_CH-1:0];
   end

   assign irq_o = |(irq_status & irq_enable);

   upper_reset_a: assert property (@(posedge mclk_i) $rose(resetn_i) |-> cfg[0].upper == 16'h0064)
      else $error("upper limit reset value wrong");

   // ==========================================================
   // Checks on registers, events and timebase
   // new event beats clear
   set_wins_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      irq_event != '0 |=> (irq_status & $past(irq_event)) == $past(irq_event))
      else $error("status event lost");

   clear_works_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (irq_clear & ~irq_event) != '0 |=> (irq_status & $past(irq_clear & ~irq_event)) == '0)
      else $error("status bit not cleared");

   enable_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_hit(thresh_pkg::OFS_IRQ_ENABLE) |=> irq_enable == $past(hwdata_i[2*NUM_CH-1:0]))
      else $error("enable mask not written");

   switch_event_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ch_cond != cond_d |=> (irq_status[NUM_CH-1:0] & $past(ch_cond ^ cond_d)) == $past(ch_cond ^ cond_d))
      else $error("switch event not flagged");

   ctrl_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_hit(thresh_pkg::OFS_CH_BASE) |=> cfg[0].ctrl == $past(hwdata_i[7:0]))
      else $error("control write lost");

   disabled_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !cfg[0].ctrl.enable |=> !out_o[0])
      else $error("disabled channel driven");

   limits_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_hit(thresh_pkg::OFS_CH_BASE + 12'(thresh_pkg::OFS_CH_LIMITS))
      |=> {cfg[0].upper, cfg[0].lower} == $past(hwdata_i))
      else $error("limits write lost");

   limits_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (hready_i && hsel_i && htrans_i[1] && !hwrite_i && rd_addr == thresh_pkg::OFS_CH_BASE
       + 12'(thresh_pkg::OFS_CH_LIMITS)) |=> hrdata_o == $past({cfg[0].upper, cfg[0].lower}))
      else $error("limits read wrong");

   duty_cap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cfg[0].duty <= 7'h64 && cfg[NUM_CH-1].duty <= 7'h64)
      else $error("duty above full scale");

   phase_step_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !pwm_tick |=> $stable(pwm_phase))
      else $error("phase moved without tick");

   phase_range_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      pwm_phase < 7'(thresh_pkg::PWM_STEPS))
      else $error("phase out of range");
endmodule // threshold_switch_output

/* tb/effector_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Switched effector on the eight channel outputs
module effector_model (
   input wire logic [7:0] drive_i,
   input wire logic [7:0] fault_i,
   output logic [7:0] short_o
);
   // A shorted coil only draws excess current while it is driven
   assign short_o = drive_i & fault_i;
endmodule // effector_model

/* tb/test_threshold_switch_output.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("ERROR %s expected %h seen %h", n, e, g); \
      end \
   end
module test_threshold_switch_output;
   // ==========================================================
   // Bench signals
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [7:0] short_sense;
   logic [7:0] short_cmd = 8'h00;
   logic [7:0] out;
   logic irq;
   int num_errors = 0;
   int check_count = 0;
   int hc;
   logic [15:0] lfsr = 16'h9B85;
   logic [31:0] rd;
   logic [7:0] st, inv_m, win_m;
   logic [15:0] lo [8];
   logic [15:0] up [8];
   logic [15:0] v;
   logic e;

   // Clock and single-slave ready loop
   always #5 mclk = ~mclk;
   assign hready = hreadyout;

   threshold_switch_output #(.TICK_CYCLES(10), .PWM_STEP_CYCLES(2)) uut (
      .mclk_i(mclk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .short_i(short_sense), .out_o(out), .irq_o(irq));

   effector_model partner (.drive_i(out), .fault_i(short_cmd), .short_o(short_sense));

   // ==========================================================
   // Helpers
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [31:0] chb(input int c, input logic [4:0] ofs);
      return {20'h0, thresh_pkg::OFS_CH_BASE} + (32'(c) << thresh_pkg::CH_SHIFT) + {27'h0, ofs};
   endfunction

   // Expected switched state from mode, limits and value
   function automatic logic next_st(input logic s, input logic w, input logic [15:0] x, a, b);
      if (w)
         return (x >= a) && (x <= b);
      return (x > b) ? 1'b1 : ((x < a) ? 1'b0 : s);
   endfunction

   // One single word transfer, address then data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic cfg(input int c, input logic [31:0] ctrl, input logic [31:0] dly);
      bus(1'b1, chb(c, thresh_pkg::OFS_CH_LIMITS), 32'h0014_000A);
      bus(1'b1, chb(c, thresh_pkg::OFS_CH_DELAY), dly);
      bus(1'b1, chb(c, thresh_pkg::OFS_CH_CTRL), ctrl);
   endtask

   task automatic wait_hi(input int c, input int lim);
      int n;
      n = 0;
      while (out[c] !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
   endtask

   task automatic count_hi(input int c, input int n);
      hc = 0;
      repeat (n)
      begin
         @(posedge mclk);
         hc += int'(out[c] === 1'b1);
      end
   endtask

   task close_out;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog cuts a hang short
   initial
   begin
      #500000;
      num_errors++;
      close_out();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      // Reset values of every channel and an unmapped read
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b0, chb(c, thresh_pkg::OFS_CH_LIMITS), 32'h0);
         `CHK("limits", 32'h0064_0000, rd)
         bus(1'b0, chb(c, thresh_pkg::OFS_CH_DELAY), 32'h0);
         `CHK("delay", 32'h0000_0000, rd)
         bus(1'b0, chb(c, thresh_pkg::OFS_CH_CTRL), 32'h0);
         `CHK("ctrl", 7'h12, rd[6:0])
      end
      bus(1'b0, 32'h0000_0FF0, 32'h0);
      `CHK("unmapped", 32'h0000_0000, rd)
      `CHK("ready resp", 2'b10, {hreadyout, hresp})
      // Random mode, limits and inversion per channel
      win_m = 8'(rnd());
      inv_m = 8'(rnd());
      for (int c = 0; c < 8; c++)
      begin
         lo[c] = rnd() % 16'd30000;
         up[c] = lo[c] + 16'd1 + (rnd() % 16'd30000);
         st[c] = win_m[c] & (lo[c] == 16'h0);
         bus(1'b1, chb(c, thresh_pkg::OFS_CH_LIMITS), {up[c], lo[c]});
         bus(1'b1, chb(c, thresh_pkg::OFS_CH_CTRL), {24'h0, 4'h8, inv_m[c], 2'b01, win_m[c]});
      end
      // Random values with limit corners, all outputs compared
      for (int i = 0; i < 200; i++)
      begin
         int c, k;
         c = int'(rnd() % 16'd8);
         k = int'(rnd() % 16'd6);
         v = (k == 0) ? lo[c] : (k == 1) ? up[c] : (k == 2) ? lo[c] - 16'd1 : (k == 3) ? up[c] + 16'd1 : rnd();
         bus(1'b1, chb(c, thresh_pkg::OFS_CH_INPUT), {16'h0, v});
         st[c] = next_st(st[c], win_m[c], v, lo[c], up[c]);
         repeat (6) @(posedge mclk);
         `CHK("out", st ^ inv_m, out)
      end
      bus(1'b0, {20'h0, thresh_pkg::OFS_OUT_STATE}, 32'h0);
      `CHK("out state", {st, st ^ inv_m}, rd[15:0])
      // Switching delay of five ticks, short pulse ignored
      cfg(1, 32'h82, 32'h0);
      bus(1'b1, chb(1, thresh_pkg::OFS_CH_INPUT), 32'h0);
      repeat (10) @(posedge mclk);
      bus(1'b1, chb(1, thresh_pkg::OFS_CH_DELAY), 32'h5);
      bus(1'b1, chb(1, thresh_pkg::OFS_CH_INPUT), 32'd30);
      repeat (20) @(posedge mclk);
      `CHK("delay early", 1'b0, out[1])
      bus(1'b1, chb(1, thresh_pkg::OFS_CH_INPUT), 32'd5);
      repeat (80) @(posedge mclk);
      `CHK("short pulse", 1'b0, out[1])
      bus(1'b1, chb(1, thresh_pkg::OFS_CH_INPUT), 32'd30);
      repeat (30) @(posedge mclk);
      `CHK("delay mid", 1'b0, out[1])
      wait_hi(1, 60);
      `CHK("delay end", 1'b1, out[1])
      // Fault substitution from both switched states
      cfg(2, 32'h82, 32'h0);
      for (int s = 0; s < 2; s++)
      begin
         bus(1'b1, chb(2, thresh_pkg::OFS_CH_INPUT), (s == 1) ? 32'd30 : 32'd0);
         repeat (6) @(posedge mclk);
         for (int f = 0; f < 4; f++)
         begin
            e = (f == 2) || (f == 0 && s == 1);
            bus(1'b1, chb(2, thresh_pkg::OFS_CH_CTRL), 32'hC0 | (32'(f) << 1));
            repeat (6) @(posedge mclk);
            `CHK("fault", e, out[2])
            bus(1'b1, chb(2, thresh_pkg::OFS_CH_CTRL), 32'h82);
            repeat (6) @(posedge mclk);
         end
      end
      // Short detection enable, interrupt mask and clear
      cfg(3, 32'h82, 32'h0);
      bus(1'b1, chb(3, thresh_pkg::OFS_CH_INPUT), 32'd30);
      bus(1'b1, {20'h0, thresh_pkg::OFS_IRQ_ENABLE}, 32'h0);
      bus(1'b1, {20'h0, thresh_pkg::OFS_IRQ_CLEAR}, 32'hFFFF);
      short_cmd <= 8'h08;
      repeat (6) @(posedge mclk);
      bus(1'b0, {20'h0, thresh_pkg::OFS_IRQ_STATUS}, 32'h0);
      `CHK("short off", 1'b0, rd[11])
      bus(1'b1, chb(3, thresh_pkg::OFS_CH_CTRL), 32'h92);
      repeat (4) @(posedge mclk);
      bus(1'b0, {20'h0, thresh_pkg::OFS_IRQ_STATUS}, 32'h0);
      `CHK("short on", 1'b1, rd[11])
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, {20'h0, thresh_pkg::OFS_IRQ_ENABLE}, 32'h800);
      repeat (2) @(posedge mclk);
      `CHK("irq set", 1'b1, irq)
      short_cmd <= 8'h00;
      repeat (2) @(posedge mclk);
      bus(1'b1, {20'h0, thresh_pkg::OFS_IRQ_CLEAR}, 32'h800);
      repeat (2) @(posedge mclk);
      `CHK("irq clear", 1'b0, irq)
      // Power reduction: hold of four ticks, quarter duty
      cfg(4, 32'hA2, 32'h0);
      bus(1'b1, chb(4, thresh_pkg::OFS_CH_HOLD), 32'h4);
      bus(1'b1, chb(4, thresh_pkg::OFS_CH_DUTY), 32'd25);
      for (int r = 0; r < 2; r++)
      begin
         bus(1'b1, chb(4, thresh_pkg::OFS_CH_INPUT), 32'd0);
         repeat (20) @(posedge mclk);
         bus(1'b1, chb(4, thresh_pkg::OFS_CH_INPUT), 32'd30);
         wait_hi(4, 20);
         count_hi(4, 25);
         `CHK("hold", 25, hc)
      end
      repeat (30) @(posedge mclk);
      count_hi(4, 400);
      `CHK("duty", 1'b1, hc >= 96 && hc <= 104)
      close_out();
   end
endmodule // test_threshold_switch_output
